// ---- rtl/instr_timing_map.vh ----
`ifndef INSTR_TIMING_MAP_VH
`define INSTR_TIMING_MAP_VH
// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define OP_ADD_IMM     5'h00
`define OP_AND_IMM     5'h01
`define OP_XOR_IMM     5'h02
`define OP_OR_IMM      5'h03
`define OP_SUB_IMM     5'h04
`define OP_CMP_IMM     5'h05
`define OP_ADD_QUICK   5'h06
`define OP_SUB_QUICK   5'h07
`define OP_MOVE_QUICK  5'h08
`define OP_CLEAR       5'h09
`define OP_NEGATE      5'h0a
`define OP_NEGATE_X    5'h0b
`define OP_COMPLEMENT  5'h0c
`define OP_DEC_NEGATE  5'h0d
`define OP_SET_COND    5'h0e
`define OP_TEST_SET    5'h0f
`define OP_TEST        5'h10
`define OP_ARITH_SHIFT 5'h11
`define OP_LOGIC_SHIFT 5'h12
`define OP_ROTATE      5'h13
`define OP_ROTATE_X    5'h14
`define OP_BIT_CHANGE  5'h15
`define OP_BIT_CLEAR   5'h16
`define OP_BIT_SET     5'h17
`define OP_BIT_TEST    5'h18
// ----------------------------------------------------------------
// operand location and size
// ----------------------------------------------------------------
`define LOC_DREG 2'h0
`define LOC_AREG 2'h1
`define LOC_MEM  2'h2
`define SZ_BYTE  2'h0
`define SZ_WORD  2'h1
`define SZ_LONG  2'h2
// ----------------------------------------------------------------
// base clock counts
// ----------------------------------------------------------------
`define C_IMM_DREG      8'h10
`define C_IMM_DREG_L    8'h1c
`define C_IMM_MEM_B     8'h14
`define C_IMM_MEM_W     8'h18
`define C_IMM_MEM_L     8'h28
`define C_CMP_DREG_L    8'h1a
`define C_CMP_MEM_L     8'h18
`define C_QUICK         8'h08
`define C_QUICK_L       8'h0c
`define C_QUICK_AREG    8'h0c
`define C_RMW_B         8'h0c
`define C_RMW_W         8'h10
`define C_RMW_L         8'h18
`define C_ONE_REG       8'h08
`define C_ONE_REG_L     8'h0a
`define C_DEC_REG       8'h0a
`define C_SCC_TRUE      8'h0a
`define C_TAS_MEM       8'h0e
`define C_SHIFT_REG     8'h0a
`define C_SHIFT_REG_L   8'h0c
`define C_SHIFT_MEM     8'h10
`define C_BIT_DYN_MOD   8'h0c
`define C_BIT_DYN_CLR   8'h0e
`define C_BIT_DYN_TST_R 8'h0a
`define C_BIT_DYN_TST_M 8'h08
`define C_BIT_ST_MOD    8'h14
`define C_BIT_ST_CLR_R  8'h16
`define C_BIT_ST_TST_R  8'h12
`define C_BIT_ST_TST_M  8'h10
// ----------------------------------------------------------------
// bus cycle counts and pacing
// ----------------------------------------------------------------
`define N_RD_SHORT  4'h2
`define N_RD_IMM    4'h4
`define N_RD_IMM_L  4'h6
`define N_WR_NONE   4'h0
`define N_WR_B      4'h1
`define N_WR_W      4'h2
`define N_WR_L      4'h4
`define BUS_SLOT_LAST 2'h3
`endif

// ---- rtl/cycle_counter.v ----
`timescale 1ns/1ns
module cycle_counter #(
    parameter W = 10
) (
    input  wire         clk_sys_i,
    input  wire         resetn_i,
    input  wire         ce_i,
    input  wire         load_i,
    input  wire [W-1:0] value_i,
    input  wire         dec_i,
    output reg  [W-1:0] count_o,
    output wire         zero_o
);
    // load beats decrement so a restart is never lost
    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            count_o <= {W{1'b0}};
        else if (ce_i)
        begin
            if (load_i)
                count_o <= value_i;
            else if (dec_i && !zero_o)
                count_o <= count_o - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign zero_o = (count_o == {W{1'b0}});
endmodule // cycle_counter

// ---- rtl/timing_table.v ----
`timescale 1ns/1ns
`include "instr_timing_map.vh"
module timing_table (
    input  wire       clk_sys_i,
    input  wire       resetn_i,
    input  wire       ce_i,
    input  wire       load_i,
    input  wire [4:0] op_i,
    input  wire [1:0] size_i,
    input  wire [1:0] loc_i,
    input  wire       static_bit_i,
    input  wire       cond_true_i,
    output reg  [7:0] base_clk_o,
    output reg  [3:0] base_rd_o,
    output reg  [3:0] base_wr_o,
    output reg        ea_add_o,
    output reg        per_shift_o,
    output reg        illegal_o
);
    function [7:0] pick_c;
        input [1:0] s;
        input [7:0] b;
        input [7:0] w;
        input [7:0] l;
        pick_c = (s == `SZ_BYTE) ? b : (s == `SZ_WORD) ? w : l;
    endfunction

    function [3:0] pick_n;
        input [1:0] s;
        input [3:0] b;
        input [3:0] w;
        input [3:0] l;
        pick_n = (s == `SZ_BYTE) ? b : (s == `SZ_WORD) ? w : l;
    endfunction

    reg [7:0] c;
    reg [3:0] r;
    reg [3:0] w;
    reg       ea;
    reg       sh;
    reg       bad;
    wire      dreg  = (loc_i == `LOC_DREG);
    wire      mem   = (loc_i == `LOC_MEM);
    wire      bsz   = (size_i > `SZ_LONG);
    wire      byte1 = (size_i == `SZ_BYTE);

    always @*
    begin
        c   = 8'h00;
        r   = `N_RD_SHORT;
        w   = `N_WR_NONE;
        ea  = mem;
        sh  = 1'b0;
        bad = bsz;
        case (op_i)
            `OP_ADD_IMM, `OP_AND_IMM, `OP_XOR_IMM, `OP_OR_IMM,
            `OP_SUB_IMM:
            begin
                r = pick_n(size_i, `N_RD_IMM, `N_RD_IMM, `N_RD_IMM_L);
                if (dreg)
                    c = pick_c(size_i, `C_IMM_DREG, `C_IMM_DREG,
                               `C_IMM_DREG_L);
                else if (mem)
                begin
                    c = pick_c(size_i, `C_IMM_MEM_B, `C_IMM_MEM_W,
                               `C_IMM_MEM_L);
                    w = pick_n(size_i, `N_WR_B, `N_WR_W, `N_WR_L);
                end
                else
                    bad = 1'b1;
            end
            `OP_CMP_IMM:
            begin
                r  = pick_n(size_i, `N_RD_IMM, `N_RD_IMM, `N_RD_IMM_L);
                ea = 1'b0;
                if (dreg)
                    c = pick_c(size_i, `C_IMM_DREG, `C_IMM_DREG,
                               `C_CMP_DREG_L);
                else if (mem)
                    c = pick_c(size_i, `C_IMM_DREG, `C_IMM_DREG,
                               `C_CMP_MEM_L);
                else
                    bad = 1'b1;
            end
            `OP_ADD_QUICK, `OP_SUB_QUICK:
            begin
                if (dreg)
                    c = pick_c(size_i, `C_QUICK, `C_QUICK, `C_QUICK_L);
                else if (mem)
                begin
                    c = pick_c(size_i, `C_RMW_B, `C_RMW_W, `C_RMW_L);
                    w = pick_n(size_i, `N_WR_B, `N_WR_W, `N_WR_L);
                end
                else if (op_i == `OP_ADD_QUICK && !byte1)
                    c = `C_QUICK_AREG;
                else
                    bad = 1'b1;
            end
            `OP_MOVE_QUICK:
            begin
                c   = `C_QUICK;
                bad = !dreg || size_i != `SZ_LONG;
            end
            `OP_CLEAR, `OP_NEGATE, `OP_NEGATE_X, `OP_COMPLEMENT:
            begin
                if (dreg)
                    c = pick_c(size_i, `C_ONE_REG, `C_ONE_REG,
                               `C_ONE_REG_L);
                else if (mem)
                begin
                    c = pick_c(size_i, `C_RMW_B, `C_RMW_W, `C_RMW_L);
                    w = pick_n(size_i, `N_WR_B, `N_WR_W, `N_WR_L);
                end
                else
                    bad = 1'b1;
            end
            `OP_DEC_NEGATE, `OP_SET_COND, `OP_TEST_SET:
            begin
                bad = !byte1 || !(dreg || mem);
                w   = mem ? `N_WR_B : `N_WR_NONE;
                if (op_i == `OP_DEC_NEGATE)
                    c = mem ? `C_RMW_B : `C_DEC_REG;
                else if (op_i == `OP_SET_COND)
                    c = mem ? `C_RMW_B :
                        (cond_true_i ? `C_SCC_TRUE : `C_ONE_REG);
                else
                    c = mem ? `C_TAS_MEM : `C_ONE_REG;
            end
            `OP_TEST:
            begin
                c   = `C_ONE_REG;
                bad = bsz || !(dreg || mem);
            end
            `OP_ARITH_SHIFT, `OP_LOGIC_SHIFT, `OP_ROTATE, `OP_ROTATE_X:
            begin
                if (dreg)
                begin
                    c  = pick_c(size_i, `C_SHIFT_REG, `C_SHIFT_REG,
                                `C_SHIFT_REG_L);
                    sh = 1'b1;
                end
                else if (mem && size_i == `SZ_WORD)
                begin
                    c = `C_SHIFT_MEM;
                    w = `N_WR_W;
                end
                else
                    bad = 1'b1;
            end
            `OP_BIT_CHANGE, `OP_BIT_SET, `OP_BIT_CLEAR, `OP_BIT_TEST:
            begin
                bad = bsz || !(dreg || mem);
                r   = static_bit_i ? `N_RD_IMM : `N_RD_SHORT;
                w   = (mem && op_i != `OP_BIT_TEST) ? `N_WR_B : `N_WR_NONE;
                if (op_i == `OP_BIT_TEST)
                    c = static_bit_i ?
                        (mem ? `C_BIT_ST_TST_M : `C_BIT_ST_TST_R) :
                        (mem ? `C_BIT_DYN_TST_M : `C_BIT_DYN_TST_R);
                else if (op_i == `OP_BIT_CLEAR && dreg)
                    c = static_bit_i ? `C_BIT_ST_CLR_R : `C_BIT_DYN_CLR;
                else
                    c = static_bit_i ? `C_BIT_ST_MOD : `C_BIT_DYN_MOD;
            end
            default:
                bad = 1'b1;
        endcase
    end

    // illegal entries carry zero cost so nothing is ever scheduled
    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            base_clk_o  <= 8'h00;
            base_rd_o   <= 4'h0;
            base_wr_o   <= 4'h0;
            ea_add_o    <= 1'b0;
            per_shift_o <= 1'b0;
            illegal_o   <= 1'b0;
        end
        else if (ce_i && load_i)
        begin
            base_clk_o  <= bad ? 8'h00 : c;
            base_rd_o   <= bad ? 4'h0 : r;
            base_wr_o   <= bad ? 4'h0 : w;
            ea_add_o    <= ea && !bad;
            per_shift_o <= sh && !bad;
            illegal_o   <= bad;
        end
    end
endmodule // timing_table

// ---- rtl/instruction_cycle_timing.v ----
`timescale 1ns/1ns
`include "instr_timing_map.vh"
module instruction_cycle_timing #(
    parameter CLK_W = 10,
    parameter RD_W  = 5,
    parameter WR_W  = 5
) (
    input  wire             clk_sys_i,
    input  wire             resetn_i,
    input  wire             ce_i,
    input  wire             start_i,
    input  wire [4:0]       op_i,
    input  wire [1:0]       size_i,
    input  wire [1:0]       loc_i,
    input  wire             static_bit_i,
    input  wire             cond_true_i,
    input  wire [5:0]       shift_count_i,
    input  wire [7:0]       ea_clk_i,
    input  wire [3:0]       ea_rd_i,
    input  wire [3:0]       ea_wr_i,
    output reg              ready_o,
    output reg              busy_o,
    output reg              read_cycle_o,
    output reg              write_cycle_o,
    output reg              done_o,
    output reg              illegal_o,
    output reg  [CLK_W-1:0] total_clk_o,
    output reg  [RD_W-1:0]  total_rd_o,
    output reg  [WR_W-1:0]  total_wr_o,
    output reg  [CLK_W-1:0] elapsed_clk_o,
    output reg  [RD_W-1:0]  seen_rd_o,
    output reg  [WR_W-1:0]  seen_wr_o
);
    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_LOOK = 4'b0010;
    localparam [3:0] S_RUN  = 4'b0100;
    localparam [3:0] S_END  = 4'b1000;

    reg  [3:0]       state_q;
    reg  [3:0]       state_d;
    reg  [5:0]       shift_n_q;
    reg  [7:0]       ea_clk_q;
    reg  [3:0]       ea_rd_q;
    reg  [3:0]       ea_wr_q;
    reg  [RD_W-1:0]  rd_left_q;
    reg  [WR_W-1:0]  wr_left_q;

    wire [7:0]       base_clk;
    wire [3:0]       base_rd;
    wire [3:0]       base_wr;
    wire             ea_add;
    wire             per_shift;
    wire             tbl_illegal;
    wire [CLK_W-1:0] clk_left;
    wire             clk_zero;
    wire [1:0]       slot;
    wire             slot_zero;

    // ready_o is still low on the first edge after reset, so a start there
    // is refused just as at any other time the sequencer is not ready
    wire take     = (state_q == S_IDLE) && ready_o && start_i;
    wire pending  = (rd_left_q != {RD_W{1'b0}}) ||
                    (wr_left_q != {WR_W{1'b0}});
    wire in_run   = (state_q == S_RUN);
    wire issue    = in_run && slot_zero && pending;
    wire issue_rd = issue && (rd_left_q != {RD_W{1'b0}});
    wire issue_wr = issue && !issue_rd;
    wire last_clk = (clk_left == {{(CLK_W-1){1'b0}}, 1'b1});
    wire finish   = in_run && last_clk && !pending;
    wire start_run = (state_q == S_LOOK) && !tbl_illegal;

    // ----------------------------------------------------------------
    // totals: base plus shift term plus address calculation
    // ----------------------------------------------------------------
    wire [CLK_W-1:0] shift_term = per_shift ?
        {{(CLK_W-7){1'b0}}, shift_n_q, 1'b0} : {CLK_W{1'b0}};
    wire [CLK_W-1:0] ea_clk_term = ea_add ?
        {{(CLK_W-8){1'b0}}, ea_clk_q} : {CLK_W{1'b0}};
    wire [CLK_W-1:0] sum_clk = {{(CLK_W-8){1'b0}}, base_clk}
                               + shift_term + ea_clk_term;
    wire [RD_W-1:0]  sum_rd = {{(RD_W-4){1'b0}}, base_rd} +
        (ea_add ? {{(RD_W-4){1'b0}}, ea_rd_q} : {RD_W{1'b0}});
    wire [WR_W-1:0]  sum_wr = {{(WR_W-4){1'b0}}, base_wr} +
        (ea_add ? {{(WR_W-4){1'b0}}, ea_wr_q} : {WR_W{1'b0}});

    // ----------------------------------------------------------------
    // lookup of the base cost
    // ----------------------------------------------------------------
    timing_table u_table (
        .clk_sys_i    (clk_sys_i),
        .resetn_i     (resetn_i),
        .ce_i         (ce_i),
        .load_i       (take),
        .op_i         (op_i),
        .size_i       (size_i),
        .loc_i        (loc_i),
        .static_bit_i (static_bit_i),
        .cond_true_i  (cond_true_i),
        .base_clk_o   (base_clk),
        .base_rd_o    (base_rd),
        .base_wr_o    (base_wr),
        .ea_add_o     (ea_add),
        .per_shift_o  (per_shift),
        .illegal_o    (tbl_illegal)
    );

    // ----------------------------------------------------------------
    // clocks remaining and bus slot pacing
    // ----------------------------------------------------------------
    // the final clock is held while a bus cycle is still owed, so a
    // short address cost stretches the instruction rather than drop it
    cycle_counter #(
        .W (CLK_W)
    ) u_clk_left (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .load_i    (start_run),
        .value_i   (sum_clk),
        .dec_i     (in_run && !last_clk),
        .count_o   (clk_left),
        .zero_o    (clk_zero)
    );

    cycle_counter #(
        .W (2)
    ) u_slot (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .load_i    (issue || start_run),
        .value_i   (issue ? `BUS_SLOT_LAST : 2'h0),
        .dec_i     (in_run),
        .count_o   (slot),
        .zero_o    (slot_zero)
    );

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    always @*
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (take)
                    state_d = S_LOOK;
            S_LOOK:
                state_d = tbl_illegal ? S_END : S_RUN;
            S_RUN:
                if (finish)
                    state_d = S_END;
            S_END:
                state_d = S_IDLE;
            default:
                state_d = S_IDLE;
        endcase
    end

    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state_q <= S_IDLE;
        else if (ce_i)
            state_q <= state_d;
    end

    // ----------------------------------------------------------------
    // operand capture and bus cycle bookkeeping
    // ----------------------------------------------------------------
    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            shift_n_q <= 6'h00;
            ea_clk_q  <= 8'h00;
            ea_rd_q   <= 4'h0;
            ea_wr_q   <= 4'h0;
            rd_left_q <= {RD_W{1'b0}};
            wr_left_q <= {WR_W{1'b0}};
        end
        else if (ce_i)
        begin
            if (take)
            begin
                shift_n_q <= shift_count_i;
                ea_clk_q  <= ea_clk_i;
                ea_rd_q   <= ea_rd_i;
                ea_wr_q   <= ea_wr_i;
            end
            if (start_run)
            begin
                rd_left_q <= sum_rd;
                wr_left_q <= sum_wr;
            end
            else if (issue_rd)
                rd_left_q <= rd_left_q - {{(RD_W-1){1'b0}}, 1'b1};
            else if (issue_wr)
                wr_left_q <= wr_left_q - {{(WR_W-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // handshake and bus cycle strobes
    // ----------------------------------------------------------------
    // status follows the next state so it lines up with the sequencer
    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ready_o       <= 1'b0;
            busy_o        <= 1'b0;
            read_cycle_o  <= 1'b0;
            write_cycle_o <= 1'b0;
            done_o        <= 1'b0;
        end
        else if (ce_i)
        begin
            ready_o       <= (state_d == S_IDLE);
            busy_o        <= (state_d == S_LOOK) || (state_d == S_RUN);
            read_cycle_o  <= issue_rd;
            write_cycle_o <= issue_wr;
            done_o        <= (state_d == S_END);
        end
    end

    // ----------------------------------------------------------------
    // tabulated totals
    // ----------------------------------------------------------------
    // totals stand until the next accepted start, so they can be read
    // at leisure after done
    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            illegal_o   <= 1'b0;
            total_clk_o <= {CLK_W{1'b0}};
            total_rd_o  <= {RD_W{1'b0}};
            total_wr_o  <= {WR_W{1'b0}};
        end
        else if (ce_i)
        begin
            if (take)
                illegal_o <= 1'b0;
            else if (state_q == S_LOOK)
            begin
                illegal_o   <= tbl_illegal;
                total_clk_o <= sum_clk;
                total_rd_o  <= sum_rd;
                total_wr_o  <= sum_wr;
            end
        end
    end

    // ----------------------------------------------------------------
    // measured activity
    // ----------------------------------------------------------------
    // cleared on a start rather than on done, so the figures of the last
    // instruction stay visible while the sequencer idles
    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            elapsed_clk_o <= {CLK_W{1'b0}};
            seen_rd_o     <= {RD_W{1'b0}};
            seen_wr_o     <= {WR_W{1'b0}};
        end
        else if (ce_i)
        begin
            if (take)
            begin
                elapsed_clk_o <= {CLK_W{1'b0}};
                seen_rd_o     <= {RD_W{1'b0}};
                seen_wr_o     <= {WR_W{1'b0}};
            end
            if (in_run)
                elapsed_clk_o <= elapsed_clk_o + {{(CLK_W-1){1'b0}}, 1'b1};
            if (issue_rd)
                seen_rd_o <= seen_rd_o + {{(RD_W-1){1'b0}}, 1'b1};
            if (issue_wr)
                seen_wr_o <= seen_wr_o + {{(WR_W-1){1'b0}}, 1'b1};
        end
    end
endmodule // instruction_cycle_timing

// ---- tb/instr_timing_asserts.sv ----
`timescale 1ns/1ns
`include "instr_timing_map.vh"
module instr_timing_asserts #(
    parameter CLK_W = 10,
    parameter RD_W  = 5,
    parameter WR_W  = 5
) (
    input wire             clk_sys_i,
    input wire             resetn_i,
    input wire             ce_i,
    input wire             start_i,
    input wire [4:0]       op_i,
    input wire [1:0]       size_i,
    input wire [1:0]       loc_i,
    input wire [5:0]       shift_count_i,
    input wire             ready_o,
    input wire             busy_o,
    input wire             read_cycle_o,
    input wire             write_cycle_o,
    input wire             done_o,
    input wire             illegal_o,
    input wire [CLK_W-1:0] total_clk_o,
    input wire [RD_W-1:0]  total_rd_o,
    input wire [WR_W-1:0]  total_wr_o,
    input wire [CLK_W-1:0] elapsed_clk_o,
    input wire [RD_W-1:0]  seen_rd_o,
    input wire [WR_W-1:0]  seen_wr_o
);
    // ------------------------------------------------------------
    // timing checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    wire take = ce_i && ready_o && start_i;
    a_take_busy: assert property (take |=> busy_o && !ready_o)
        else $error("no busy after accepted start");
    a_word_imm: assert property (take && op_i == `OP_ADD_IMM
        && size_i == `SZ_WORD && loc_i == `LOC_DREG |-> ##2
        total_clk_o == 16 && total_rd_o == 4 ##16 done_o)
        else $error("word immediate add cost wrong");
    a_illegal_fast: assert property (take && size_i == 2'h3
        |-> ##2 done_o && illegal_o && total_clk_o == 0)
        else $error("illegal size not refused");
    a_cmp_no_write: assert property (take
        && op_i == `OP_CMP_IMM |-> ##2 total_wr_o == 0)
        else $error("compare has writes");
    a_shift_cost: assert property (take
        && op_i == `OP_LOGIC_SHIFT && loc_i == `LOC_DREG
        && size_i == `SZ_WORD |-> ##2
        total_clk_o == 10 + 2 * $past(shift_count_i, 2))
        else $error("register shift cost wrong");
    a_done_pulse: assert property (done_o
        |=> !done_o && ready_o)
        else $error("done not a single pulse");
    a_counts_match: assert property (done_o && !illegal_o |->
        seen_rd_o == total_rd_o && seen_wr_o == total_wr_o
        && elapsed_clk_o == total_clk_o) else $error("measured differs");
    a_one_kind: assert property (!(read_cycle_o
        && write_cycle_o))
        else $error("read and write together");
    a_bus_pace: assert property (read_cycle_o || write_cycle_o
        |=> !(read_cycle_o || write_cycle_o) [*3])
        else $error("bus cycles too close");
    c_illegal: cover property (done_o && illegal_o);
    c_writes: cover property (done_o && !illegal_o && seen_wr_o != 0);
    c_read: cover property (read_cycle_o);
endmodule // instr_timing_asserts

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`include "instr_timing_map.vh"
bind instruction_cycle_timing instr_timing_asserts #(.CLK_W(CLK_W),
    .RD_W(RD_W), .WR_W(WR_W)) chk_i (.*);
module tb;
    reg        clk_sys_i = 0, resetn_i = 0, ce_i = 1, start_i = 0;
    reg        static_bit_i = 0, cond_true_i = 0;
    reg  [4:0] op_i = 0;
    reg  [1:0] size_i = 0, loc_i = 0;
    reg  [5:0] shift_count_i = 0;
    reg  [7:0] ea_clk_i = 8'h06;
    reg  [3:0] ea_rd_i = 4'h1, ea_wr_i = 4'h1;
    wire       ready_o, busy_o, read_cycle_o, write_cycle_o, done_o, illegal_o;
    wire [9:0] total_clk_o, elapsed_clk_o;
    wire [4:0] total_rd_o, total_wr_o, seen_rd_o, seen_wr_o;
    integer    miscompares = 0, n_compared = 0, cyc = 0, k, frz = 0;
    instruction_cycle_timing instruction_cycle_timing_i (.*);
    initial forever #10 clk_sys_i = ~clk_sys_i;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task check(input [79:0] nm, input [9:0] e, input [9:0] g);
    begin
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0s expected %0d seen %0d", nm, e, g);
        end
    end
    endtask
    // c == 0 means the combination must be refused; e adds address cost
    task go(input [4:0] o, input [1:0] s, l, m, input [5:0] n,
            input [9:0] c, input [4:0] r, w, input e);
        reg [9:0] ec;
        reg [4:0] er, ew;
    begin
        ec = e ? c + 6 : c;
        er = e ? r + 1 : r;
        ew = e ? w + 1 : w;
        do @(negedge clk_sys_i); while (ready_o !== 1'b1);
        @(posedge clk_sys_i);
        {op_i, size_i, loc_i, static_bit_i, cond_true_i} <= {o, s, l, m};
        shift_count_i <= n;
        start_i <= 1;
        @(posedge clk_sys_i);
        start_i <= 0;
        // frozen cycles must not count towards the measured figures
        if (frz > 0)
        begin
            ce_i <= 0;
            repeat (frz) @(posedge clk_sys_i);
            ce_i <= 1;
        end
        k = 0;
        do begin @(negedge clk_sys_i); k = k + 1; end
        while (done_o !== 1'b1 && k < 300);
        check("done", 1, done_o);
        check("illegal", c == 0, illegal_o);
        check("clocks", ec, total_clk_o);
        check("reads", er, total_rd_o);
        check("writes", ew, total_wr_o);
        check("seen rd", er, seen_rd_o);
        check("seen wr", ew, seen_wr_o);
        if (c != 0) check("elapsed", ec, elapsed_clk_o);
    end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_immediate;
    begin
        go(`OP_ADD_IMM,`SZ_WORD,`LOC_DREG,0,9,16,4,0,0);
        go(`OP_SUB_IMM,`SZ_LONG,`LOC_DREG,0,0,28,6,0,0);
        go(`OP_AND_IMM,`SZ_BYTE,`LOC_MEM,0,0,20,4,1,1);
        go(`OP_XOR_IMM,`SZ_WORD,`LOC_MEM,0,0,24,4,2,1);
        go(`OP_OR_IMM,`SZ_LONG,`LOC_MEM,0,0,40,6,4,1);
        go(`OP_CMP_IMM,`SZ_LONG,`LOC_DREG,0,0,26,6,0,0);
        go(`OP_CMP_IMM,`SZ_LONG,`LOC_MEM,0,0,24,6,0,0);
    end
    endtask
    task t_single;
    begin
        go(`OP_ADD_QUICK,`SZ_LONG,`LOC_DREG,0,0,12,2,0,0);
        go(`OP_ADD_QUICK,`SZ_WORD,`LOC_AREG,0,0,12,2,0,0);
        go(`OP_MOVE_QUICK,`SZ_LONG,`LOC_DREG,0,0,8,2,0,0);
        go(`OP_NEGATE,`SZ_LONG,`LOC_MEM,0,0,24,2,4,1);
        go(`OP_SET_COND,`SZ_BYTE,`LOC_DREG,1,0,10,2,0,0);
        go(`OP_SET_COND,`SZ_BYTE,`LOC_DREG,0,0,8,2,0,0);
        go(`OP_TEST_SET,`SZ_BYTE,`LOC_MEM,0,0,14,2,1,1);
        go(`OP_DEC_NEGATE,`SZ_BYTE,`LOC_DREG,0,0,10,2,0,0);
    end
    endtask
    task t_shift_bit;
    begin
        go(`OP_LOGIC_SHIFT,`SZ_WORD,`LOC_DREG,0,5,20,2,0,0);
        go(`OP_ROTATE,`SZ_LONG,`LOC_DREG,0,63,138,2,0,0);
        go(`OP_ROTATE_X,`SZ_WORD,`LOC_MEM,0,7,16,2,2,1);
        go(`OP_BIT_CLEAR,`SZ_BYTE,`LOC_DREG,0,0,14,2,0,0);
        go(`OP_BIT_TEST,`SZ_BYTE,`LOC_MEM,0,0,8,2,0,1);
        go(`OP_BIT_CHANGE,`SZ_BYTE,`LOC_DREG,2,0,20,4,0,0);
        go(`OP_BIT_TEST,`SZ_BYTE,`LOC_MEM,2,0,16,4,0,1);
    end
    endtask
    task t_refused;
    begin
        go(`OP_ADD_IMM,2'h3,`LOC_DREG,0,0,0,0,0,0);
        go(`OP_ARITH_SHIFT,`SZ_LONG,`LOC_MEM,0,0,0,0,0,0);
        go(`OP_SUB_QUICK,`SZ_WORD,`LOC_AREG,0,0,0,0,0,0);
        go(`OP_BIT_SET,2'h3,`LOC_DREG,0,0,0,0,0,0);
    end
    endtask
    task t_freeze;
    begin
        frz = 5;
        go(`OP_TEST,`SZ_LONG,`LOC_MEM,0,0,8,2,0,1);
        frz = 0;
    end
    endtask
    task stop_test;
    begin
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    always @(posedge clk_sys_i)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            miscompares = miscompares + 1;
            stop_test;
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        resetn_i <= 1;
        t_immediate;
        t_single;
        t_shift_bit;
        t_refused;
        t_freeze;
        stop_test;
    end
endmodule // tb
